// >>> src/afdpi_pkg.sv
// afd packet inserter: shared constants, register map, packet layout
// assumes a single 125 MHz video parallel clock for all users
package afdpi_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_AFD        = 8'h04;
  localparam logic [7:0] OFS_FLAGS      = 8'h08;
  localparam logic [7:0] OFS_BAR1       = 8'h0C;
  localparam logic [7:0] OFS_BAR2       = 8'h10;
  localparam logic [7:0] OFS_LINE       = 8'h14;
  localparam logic [7:0] OFS_SAMPLE     = 8'h18;
  localparam logic [7:0] OFS_LINE_LIM   = 8'h1C;
  localparam logic [7:0] OFS_SAMPLE_LIM = 8'h20;
  localparam logic [7:0] OFS_STATUS     = 8'h24;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned LINE_W   = 11;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned CTRL_PAR_BIT  = 2;
  localparam int unsigned CTRL_CHAN_BIT = 3;
  localparam int unsigned AFD_AR_BIT    = 4;
  localparam int unsigned ST_DONE_BIT   = 2;
  localparam int unsigned ST_CNT_LSB    = 16;
  localparam logic [LINE_W-1:0]   LINE_RST       = 11'h009;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST     = 12'h000;
  localparam logic [LINE_W-1:0]   LINE_LIM_RST   = 11'h029;
  localparam logic [SAMPLE_W-1:0] SAMPLE_LIM_RST = 12'h780;

  // ----------------------------------------------------------------
  // packet layout: flag, did, sdid, dc, 8 user words, checksum
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 10;
  localparam int unsigned IDX_W  = 4;
  localparam logic [9:0] ADF_ZERO = 10'h000;
  localparam logic [9:0] ADF_ONES = 10'h3FF;
  localparam logic [7:0] AFD_DID  = 8'h41;
  localparam logic [7:0] AFD_SDID = 8'h05;
  localparam logic [7:0] AFD_DC   = 8'h08;
  localparam logic [IDX_W-1:0] IDX_DID  = 4'h3;
  localparam logic [IDX_W-1:0] IDX_SDID = 4'h4;
  localparam logic [IDX_W-1:0] IDX_DC   = 4'h5;
  localparam logic [IDX_W-1:0] IDX_UDW0 = 4'h6;
  localparam logic [IDX_W-1:0] IDX_UDW3 = 4'h9;
  localparam logic [IDX_W-1:0] IDX_UDW4 = 4'hA;
  localparam logic [IDX_W-1:0] IDX_UDW5 = 4'hB;
  localparam logic [IDX_W-1:0] IDX_UDW6 = 4'hC;
  localparam logic [IDX_W-1:0] IDX_UDW7 = 4'hD;
  localparam logic [IDX_W-1:0] IDX_CS   = 4'hE;
  localparam logic [SAMPLE_W:0] PKT_LEN = 13'h000F;

  // payload output modes
  typedef enum logic [1:0] {
    AFDPI_OUT_OFF    = 2'h0,
    AFDPI_OUT_CONT   = 2'h1,
    AFDPI_OUT_SINGLE = 2'h2
  } afdpi_mode_t;

endpackage : afdpi_pkg

// >>> src/afdpi_mem_if.sv
// afd packet inserter: link between the controller and the packet store
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface afdpi_mem_if;
  import afdpi_pkg::*;
  logic              we;
  logic [IDX_W-1:0]  waddr;
  logic [WORD_W-1:0] wdata;
  logic [IDX_W-1:0]  raddr;
  logic [WORD_W-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : afdpi_mem_if
`default_nettype wire

// >>> src/afdpi_word_mem.sv
// afd packet inserter: sixteen word packet store, registered read
// assumes writer and reader share clk_sys_i and the clock enable
`timescale 1ns/1ps
`default_nettype none
module afdpi_word_mem (
  input  wire logic clk_sys_i,
  input  wire logic ce_i,
  afdpi_mem_if.mem  port
);
  import afdpi_pkg::*;

  logic [WORD_W-1:0] mem_q [2**IDX_W];
  logic [WORD_W-1:0] rdata_q;

  // storage has no reset: builder fills it before insertion is allowed
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (port.we) begin
        mem_q[port.waddr] <= port.wdata;
      end
      rdata_q <= mem_q[port.raddr];
    end
  end

  assign port.rdata = rdata_q;

endmodule : afdpi_word_mem
`default_nettype wire

// >>> src/afdpi_inserter.sv
// afd packet inserter: register file, packet builder and video inserter
// assumes video words and their position tags arrive on clk_sys_i from logic
`timescale 1ns/1ps
`default_nettype none
module afdpi_inserter (
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           ce_i,
  input  wire logic [afdpi_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [afdpi_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output logic      [afdpi_pkg::DATA_W-1:0]   reg_rdata_o,
  input  wire logic                           vid_valid_i,
  input  wire logic [afdpi_pkg::WORD_W-1:0]   vid_luma_i,
  input  wire logic [afdpi_pkg::WORD_W-1:0]   vid_chroma_i,
  input  wire logic [afdpi_pkg::LINE_W-1:0]   vid_line_i,
  input  wire logic [afdpi_pkg::SAMPLE_W-1:0] vid_sample_i,
  input  wire logic                           vid_active_i,
  input  wire logic                           vid_protect_i,
  output logic                                vid_valid_o,
  output logic      [afdpi_pkg::WORD_W-1:0]   vid_luma_o,
  output logic      [afdpi_pkg::WORD_W-1:0]   vid_chroma_o,
  output logic                                vid_ins_o
);
  import afdpi_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // even parity into bit 8, inverse into bit 9
  function automatic logic [WORD_W-1:0] with_parity(input logic [7:0] b, input logic auto_par);
    logic p;
    p = ^b;
    with_parity = auto_par ? {~p, p, b} : {2'b00, b};
  endfunction : with_parity

  function automatic logic [DATA_W-1:0] zext16(input logic [CNT_W-1:0] v);
    zext16 = {{(DATA_W-CNT_W){1'b0}}, v};
  endfunction : zext16

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  afdpi_mode_t         mode_q,  mode_d;
  logic                par_q,   par_d;
  logic                chan_q,  chan_d;
  logic [3:0]          code_q,  code_d;
  logic                aspect_ratio_bit_q, aspect_ratio_bit_d;
  logic [3:0]          flags_q, flags_d;
  logic [15:0]         bar1_q,  bar1_d;
  logic [15:0]         bar2_q,  bar2_d;
  logic [LINE_W-1:0]   line_q,  line_d;
  logic [SAMPLE_W-1:0] samp_q,  samp_d;
  logic [LINE_W-1:0]   llim_q,  llim_d;
  logic [SAMPLE_W-1:0] slim_q,  slim_d;
  logic                done_q,  done_d;
  logic [DATA_W-1:0]   rdata_q, rdata_d;
  logic                dirty_q, dirty_d;
  logic                pkt_end;      // last packet word taken this cycle
  logic                ready_q;
  logic                busy_q;
  logic [CNT_W-1:0]    icnt_q;
  logic                bld_start;    // builder leaves idle this cycle
  logic                hit;          // packet starts on this sample

  // decode, write effects and read mux
  always_comb begin
    mode_d = mode_q;  par_d = par_q;  chan_d = chan_q;
    code_d = code_q;  aspect_ratio_bit_d = aspect_ratio_bit_q;
    flags_d = flags_q;  bar1_d = bar1_q;  bar2_d = bar2_q;
    line_d = line_q;  samp_d = samp_q;  llim_d = llim_q;  slim_d = slim_q;
    done_d = done_q;  rdata_d = '0;
    // a payload write in the build start cycle sets dirty again below
    dirty_d = dirty_q && !bld_start;
    if (reg_wr_i) begin
      if (reg_addr_i == OFS_CTRL) begin
        mode_d = afdpi_mode_t'(reg_wdata_i[1:0]);
        par_d  = reg_wdata_i[CTRL_PAR_BIT];
        chan_d = reg_wdata_i[CTRL_CHAN_BIT];
        dirty_d = 1'b1;
      end else if (reg_addr_i == OFS_AFD) begin
        code_d = reg_wdata_i[3:0];
        aspect_ratio_bit_d = reg_wdata_i[AFD_AR_BIT];
        dirty_d = 1'b1;
      end else if (reg_addr_i == OFS_FLAGS) begin
        flags_d = reg_wdata_i[3:0];
        dirty_d = 1'b1;
      end else if (reg_addr_i == OFS_BAR1) begin
        bar1_d = reg_wdata_i[15:0];
        dirty_d = 1'b1;
      end else if (reg_addr_i == OFS_BAR2) begin
        bar2_d = reg_wdata_i[15:0];
        dirty_d = 1'b1;
      end else if (reg_addr_i == OFS_LINE) begin
        line_d = reg_wdata_i[LINE_W-1:0];
      end else if (reg_addr_i == OFS_SAMPLE) begin
        samp_d = reg_wdata_i[SAMPLE_W-1:0];
      end else if (reg_addr_i == OFS_LINE_LIM) begin
        llim_d = reg_wdata_i[LINE_W-1:0];
      end else if (reg_addr_i == OFS_SAMPLE_LIM) begin
        slim_d = reg_wdata_i[SAMPLE_W-1:0];
      end else if (reg_addr_i == OFS_STATUS) begin
        if (reg_wdata_i[ST_DONE_BIT]) begin
          done_d = 1'b0;               // write one to clear
        end
      end
    end
    // single shot falls back to off once sent; hardware wins over a write
    if (pkt_end && mode_q == AFDPI_OUT_SINGLE) begin
      mode_d = AFDPI_OUT_OFF;
      done_d = 1'b1;
    end
    if (reg_rd_i) begin
      if (reg_addr_i == OFS_CTRL) begin
        rdata_d = {{(DATA_W-4){1'b0}}, chan_q, par_q, mode_q};
      end else if (reg_addr_i == OFS_AFD) begin
        rdata_d = {{(DATA_W-5){1'b0}}, aspect_ratio_bit_q, code_q};
      end else if (reg_addr_i == OFS_FLAGS) begin
        rdata_d = {{(DATA_W-4){1'b0}}, flags_q};
      end else if (reg_addr_i == OFS_BAR1) begin
        rdata_d = zext16(bar1_q);
      end else if (reg_addr_i == OFS_BAR2) begin
        rdata_d = zext16(bar2_q);
      end else if (reg_addr_i == OFS_LINE) begin
        rdata_d = {{(DATA_W-LINE_W){1'b0}}, line_q};
      end else if (reg_addr_i == OFS_SAMPLE) begin
        rdata_d = {{(DATA_W-SAMPLE_W){1'b0}}, samp_q};
      end else if (reg_addr_i == OFS_LINE_LIM) begin
        rdata_d = {{(DATA_W-LINE_W){1'b0}}, llim_q};
      end else if (reg_addr_i == OFS_SAMPLE_LIM) begin
        rdata_d = {{(DATA_W-SAMPLE_W){1'b0}}, slim_q};
      end else if (reg_addr_i == OFS_STATUS) begin
        rdata_d = {icnt_q, {(ST_CNT_LSB-3){1'b0}}, done_q, busy_q, ready_q};
      end
    end
  end

  // auto parity is the reset choice
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= AFDPI_OUT_OFF;  par_q <= 1'b1;  chan_q <= 1'b0;
      code_q <= '0;  aspect_ratio_bit_q <= 1'b0;  flags_q <= '0;
      bar1_q <= '0;  bar2_q <= '0;
      line_q <= LINE_RST;  samp_q <= SAMPLE_RST;
      llim_q <= LINE_LIM_RST;  slim_q <= SAMPLE_LIM_RST;
      done_q <= 1'b0;  rdata_q <= '0;  dirty_q <= 1'b1;
    end else if (ce_i) begin
      mode_q <= mode_d;  par_q <= par_d;  chan_q <= chan_d;
      code_q <= code_d;  aspect_ratio_bit_q <= aspect_ratio_bit_d;  flags_q <= flags_d;
      bar1_q <= bar1_d;  bar2_q <= bar2_d;
      line_q <= line_d;  samp_q <= samp_d;  llim_q <= llim_d;  slim_q <= slim_d;
      done_q <= done_d;  rdata_q <= rdata_d;
      dirty_q <= dirty_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // packet builder: refreshes the store when payload settings change
  // ----------------------------------------------------------------
  typedef enum logic {AFDPI_BLD_IDLE, AFDPI_BLD_RUN} afdpi_bld_t;
  afdpi_bld_t        bst_q,  bst_d;
  logic [IDX_W-1:0]  bidx_q, bidx_d;
  logic [8:0]        csum_q, csum_d;
  logic              ready_d;
  logic [7:0]        byte_v;
  logic [WORD_W-1:0] word_v;
  afdpi_mem_if       mif ();

  // building never overlaps a packet on the wire
  assign bld_start = (bst_q == AFDPI_BLD_IDLE) && dirty_q && !busy_q && !hit;

  always_comb begin
    bst_d = bst_q;  bidx_d = bidx_q;  csum_d = csum_q;  ready_d = ready_q;
    byte_v = 8'h00;
    word_v = '0;
    if (bidx_q == IDX_DID) begin
      byte_v = AFD_DID;
    end else if (bidx_q == IDX_SDID) begin
      byte_v = AFD_SDID;
    end else if (bidx_q == IDX_DC) begin
      byte_v = AFD_DC;
    end else if (bidx_q == IDX_UDW0) begin
      byte_v = {1'b0, code_q, aspect_ratio_bit_q, 2'b00};
    end else if (bidx_q == IDX_UDW3) begin
      byte_v = {flags_q, 4'h0};
    end else if (bidx_q == IDX_UDW4) begin
      byte_v = bar1_q[15:8];
    end else if (bidx_q == IDX_UDW5) begin
      byte_v = bar1_q[7:0];
    end else if (bidx_q == IDX_UDW6) begin
      byte_v = bar2_q[15:8];
    end else if (bidx_q == IDX_UDW7) begin
      byte_v = bar2_q[7:0];
    end
    if (bidx_q == 4'h0) begin
      word_v = ADF_ZERO;
    end else if (bidx_q < IDX_DID) begin
      word_v = ADF_ONES;
    end else if (bidx_q == IDX_CS) begin
      // checksum bit 9 inverts bit 8
      word_v = {~csum_q[8], csum_q};
    end else begin
      word_v = with_parity(byte_v, par_q);
    end
    case (bst_q)
      AFDPI_BLD_IDLE: begin
        if (bld_start) begin
          bst_d = AFDPI_BLD_RUN;  bidx_d = '0;  csum_d = '0;  ready_d = 1'b0;
        end
      end
      AFDPI_BLD_RUN: begin
        // nine-bit sum did through last payload word
        if (bidx_q >= IDX_DID && bidx_q < IDX_CS) begin
          csum_d = csum_q + word_v[8:0];
        end
        bidx_d = bidx_q + 4'h1;
        if (bidx_q == IDX_CS) begin
          bst_d = AFDPI_BLD_IDLE;  ready_d = 1'b1;
        end
      end
      default: bst_d = AFDPI_BLD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bst_q <= AFDPI_BLD_IDLE;  bidx_q <= '0;  csum_q <= '0;  ready_q <= 1'b0;
    end else if (ce_i) begin
      bst_q <= bst_d;  bidx_q <= bidx_d;  csum_q <= csum_d;  ready_q <= ready_d;
    end
  end

  assign mif.we    = (bst_q == AFDPI_BLD_RUN);
  assign mif.waddr = bidx_q;
  assign mif.wdata = word_v;

  afdpi_word_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .port      (mif.mem)
  );

  // ----------------------------------------------------------------
  // inserter on the video path
  // ----------------------------------------------------------------
  logic              busy_d;
  logic [IDX_W-1:0]  idx_q,  idx_d;
  logic [CNT_W-1:0]  icnt_d;
  logic              in_range, take;
  logic              s1_valid_q, s1_ins_q;
  logic [WORD_W-1:0] s1_luma_q, s1_chroma_q;
  logic              o_valid_q, o_ins_q;
  logic [WORD_W-1:0] o_luma_q, o_chroma_q, o_luma_d, o_chroma_d;

  // placement must fit inside the format's ancillary space
  assign in_range = (line_q <= llim_q) && (({1'b0, samp_q} + PKT_LEN) <= {1'b0, slim_q});
  // start at the chosen spot while a mode is armed
  assign hit  = !busy_q && ready_q && (mode_q != AFDPI_OUT_OFF) && in_range && vid_valid_i
                && vid_active_i && (vid_line_i == line_q) && (vid_sample_i == samp_q);
  // audio and crc words pass; the packet slides past them
  assign take = (busy_q || hit) && vid_valid_i && vid_active_i && !vid_protect_i;
  assign pkt_end   = take && (idx_q == IDX_CS);
  assign mif.raddr = idx_q;

  always_comb begin
    busy_d = busy_q;  idx_d = idx_q;  icnt_d = icnt_q;
    if (hit) begin
      busy_d = 1'b1;
    end
    if (take) begin
      idx_d = idx_q + 4'h1;
    end
    if (pkt_end) begin
      busy_d = 1'b0;  idx_d = '0;  icnt_d = icnt_q + 16'h0001;
    end else if (busy_q && vid_valid_i && !vid_active_i) begin
      // line ran out before the packet fit: drop the rest, never touch timing words
      busy_d = 1'b0;  idx_d = '0;
    end
  end

  // output mux: store data arrive one cycle after the read address
  always_comb begin
    o_luma_d   = s1_luma_q;
    o_chroma_d = s1_chroma_q;
    if (s1_ins_q && !chan_q) begin
      o_luma_d = mif.rdata;
    end else if (s1_ins_q) begin
      o_chroma_d = mif.rdata;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;  idx_q <= '0;  icnt_q <= '0;
      s1_valid_q <= 1'b0;  s1_ins_q <= 1'b0;  s1_luma_q <= '0;  s1_chroma_q <= '0;
      o_valid_q <= 1'b0;  o_ins_q <= 1'b0;  o_luma_q <= '0;  o_chroma_q <= '0;
    end else if (ce_i) begin
      busy_q <= busy_d;  idx_q <= idx_d;  icnt_q <= icnt_d;
      s1_valid_q <= vid_valid_i;  s1_ins_q <= take;
      s1_luma_q <= vid_luma_i;  s1_chroma_q <= vid_chroma_i;
      o_valid_q <= s1_valid_q;  o_ins_q <= s1_ins_q;
      o_luma_q <= o_luma_d;  o_chroma_q <= o_chroma_d;
    end
  end

  assign vid_valid_o  = o_valid_q;
  assign vid_ins_o    = o_ins_q;
  assign vid_luma_o   = o_luma_q;
  assign vid_chroma_o = o_chroma_q;

endmodule : afdpi_inserter
`default_nettype wire

// >>> verif/afdpi_checker.sv
// afd packet inserter checker: port timing and packet header properties
// assumes it is bound onto afdpi_inserter with ce_i held high
`timescale 1ns/1ps
`default_nettype none
module afdpi_checker (
  input wire logic                         clk_sys_i,
  input wire logic                         rst_n_i,
  input wire logic [afdpi_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [afdpi_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic                         reg_wr_i,
  input wire logic                         reg_rd_i,
  input wire logic [afdpi_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic                         vid_valid_i,
  input wire logic [afdpi_pkg::WORD_W-1:0] vid_luma_i,
  input wire logic [afdpi_pkg::WORD_W-1:0] vid_chroma_i,
  input wire logic                         vid_active_i,
  input wire logic                         vid_protect_i,
  input wire logic                         vid_valid_o,
  input wire logic [afdpi_pkg::WORD_W-1:0] vid_luma_o,
  input wire logic [afdpi_pkg::WORD_W-1:0] vid_chroma_o,
  input wire logic                         vid_ins_o
);
  import afdpi_pkg::*;
  logic              par_q, par_d, chan_q, chan_d;
  logic [WORD_W-1:0] w;
  // mirror of parity and channel bits; ctrl writes land next cycle
  always_comb begin
    par_d  = par_q;
    chan_d = chan_q;
    if (reg_wr_i && reg_addr_i == OFS_CTRL) begin
      par_d  = reg_wdata_i[CTRL_PAR_BIT];
      chan_d = reg_wdata_i[CTRL_CHAN_BIT];
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_q  <= 1'b1;
      chan_q <= 1'b0;
    end else begin
      par_q  <= par_d;
      chan_q <= chan_d;
    end
  end
  // word on the selected channel
  assign w = chan_q ? vid_chroma_o : vid_luma_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // three flag words open every packet
  sequence s_adf;
    vid_ins_o && w == ADF_ZERO ##1 vid_ins_o && w == ADF_ONES ##1 vid_ins_o && w == ADF_ONES;
  endsequence
  AST_VALID_LAT: assert property (vid_valid_o == $past(vid_valid_i, 2))
    else $error("valid output not two cycles behind input");
  AST_INS_QUAL: assert property (vid_ins_o |-> vid_valid_o && $past(vid_active_i, 2) && !$past(vid_protect_i, 2))
    else $error("packet word placed on inactive or protected sample");
  // pipe still holds reset zeros for two cycles after release
  AST_PASS: assert property ($past(rst_n_i, 2) && !vid_ins_o |-> vid_luma_o == $past(vid_luma_i, 2) && vid_chroma_o == $past(vid_chroma_i, 2))
    else $error("video changed outside packet words");
  AST_OTHER_CH: assert property (vid_ins_o && !chan_q |-> vid_chroma_o == $past(vid_chroma_i, 2))
    else $error("unselected channel disturbed");
  AST_PAR_INV: assert property (vid_ins_o && par_q && w != ADF_ZERO && w != ADF_ONES |-> w[9] == !w[8])
    else $error("bit nine not inverse of bit eight");
  AST_DID: assert property (s_adf ##1 vid_ins_o |-> w == (par_q ? 10'h241 : 10'h041))
    else $error("data id word wrong");
  AST_IDS: assert property (s_adf ##1 vid_ins_o [*3] |-> w == (par_q ? 10'h108 : 10'h008) && $past(w) == (par_q ? 10'h205 : 10'h005))
    else $error("secondary id or count word wrong");
  AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside read answer cycle");
  AST_UNMAP: assert property (reg_rd_i && reg_addr_i > OFS_STATUS |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
endmodule : afdpi_checker
bind afdpi_inserter afdpi_checker u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .vid_valid_i(vid_valid_i),
  .vid_luma_i(vid_luma_i), .vid_chroma_i(vid_chroma_i), .vid_active_i(vid_active_i),
  .vid_protect_i(vid_protect_i), .vid_valid_o(vid_valid_o), .vid_luma_o(vid_luma_o),
  .vid_chroma_o(vid_chroma_o), .vid_ins_o(vid_ins_o)
);
`default_nettype wire

// >>> verif/afdpi_vid_src.sv
// afd packet inserter bench: video line source in place of the pattern path
// assumes the inserter clock; one 40-sample line per go_i pulse
`timescale 1ns/1ps
`default_nettype none
module afdpi_vid_src (
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           go_i,
  input  wire logic [afdpi_pkg::LINE_W-1:0]   line_i,
  input  wire logic [afdpi_pkg::SAMPLE_W-1:0] prot_at_i,
  output logic                                busy_o,
  output logic                                vid_valid_o,
  output logic      [afdpi_pkg::WORD_W-1:0]   vid_luma_o,
  output logic      [afdpi_pkg::WORD_W-1:0]   vid_chroma_o,
  output logic      [afdpi_pkg::LINE_W-1:0]   vid_line_o,
  output logic      [afdpi_pkg::SAMPLE_W-1:0] vid_sample_o,
  output logic                                vid_active_o,
  output logic                                vid_protect_o
);
  import afdpi_pkg::*;
  logic [5:0] cnt_q;
  logic       run_q;
  logic [9:0] pat_q;
  // line sequencer; filler keeps idle fields moving
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      pat_q <= '0;
    end else begin
      pat_q <= ~pat_q + 10'h0D3;
      run_q <= go_i | (run_q && cnt_q != 6'd39);
      cnt_q <= run_q ? cnt_q + 6'd1 : 6'd0;
    end
  end
  assign busy_o       = run_q;
  assign vid_valid_o  = run_q;
  assign vid_luma_o   = run_q ? {4'h1, cnt_q} : pat_q;
  assign vid_chroma_o = ~vid_luma_o;
  assign vid_line_o   = run_q ? line_i : {1'b0, pat_q};
  assign vid_sample_o = run_q ? {6'h00, cnt_q} : {2'b00, pat_q};
  assign vid_active_o  = run_q && cnt_q < 6'd36;
  assign vid_protect_o = run_q && {6'h00, cnt_q} == prot_at_i;
endmodule : afdpi_vid_src
`default_nettype wire

// >>> verif/afd_anc_packet_inserter_bench.sv
// afd packet inserter bench: register tasks, line runs and packet compare
// assumes the video source model and the bound checker compile alongside
`timescale 1ns/1ps
`default_nettype none
module afd_anc_packet_inserter_bench;
  import afdpi_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic [7:0]  addr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat, v;
  logic [10:0] lin = '0, vl;
  logic [11:0] prot = '0, vs;
  logic        busy, vv, va, vp, ov, oi;
  logic [9:0]  vy, vc, oy, oc;
  logic [9:0]  cap[$];
  logic        csel = 1'b0;
  logic [7:0]  afd_b = {1'b0, 4'h9, 1'b1, 2'b00};
  logic [7:0]  flg_b = {4'hA, 4'h0};
  logic [15:0] bar1 = 16'h12F0, bar2 = 16'h00FF;
  int          error_cnt = 0;
  int          check_count = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  afdpi_vid_src src (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go), .line_i(lin), .prot_at_i(prot),
    .busy_o(busy), .vid_valid_o(vv), .vid_luma_o(vy), .vid_chroma_o(vc), .vid_line_o(vl),
    .vid_sample_o(vs), .vid_active_o(va), .vid_protect_o(vp));
  afdpi_inserter dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .vid_valid_i(vv),
    .vid_luma_i(vy), .vid_chroma_i(vc), .vid_line_i(vl), .vid_sample_i(vs), .vid_active_i(va),
    .vid_protect_i(vp), .vid_valid_o(ov), .vid_luma_o(oy), .vid_chroma_o(oc), .vid_ins_o(oi));
  // collect every word flagged as inserted
  always @(posedge clk_sys_i) begin
    if (oi === 1'b1) begin
      cap.push_back(csel ? oc : oy);
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg
  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 d = rdat;
  endtask : rd_reg
  // one line, then let the two-stage pipe drain
  task automatic run_line(input logic [10:0] l, input logic [11:0] p);
    cap.delete();
    @(posedge clk_sys_i);
    go <= 1'b1;
    lin <= l;
    prot <= p;
    @(posedge clk_sys_i);
    go <= 1'b0;
    @(posedge clk_sys_i);
    for (int i = 0; i < 60 && busy === 1'b1; i++) @(posedge clk_sys_i);
    repeat (4) @(posedge clk_sys_i);
  endtask : run_line
  // expected words built from the payload settings
  task automatic chk_pkt(input logic a, input int n);
    logic [7:0] b[11];
    logic [9:0] e[15];
    logic [8:0] cs;
    b = '{8'h41, 8'h05, 8'h08, afd_b, 8'h00, 8'h00, flg_b, bar1[15:8], bar1[7:0], bar2[15:8], bar2[7:0]};
    cs = '0;
    e[0] = ADF_ZERO;
    e[1] = ADF_ONES;
    e[2] = ADF_ONES;
    for (int i = 0; i < 11; i++) begin
      e[i+3] = a ? {~^b[i], ^b[i], b[i]} : {2'b00, b[i]};
      cs = cs + e[i+3][8:0];
    end
    e[14] = {~cs[8], cs};
    check(32'(cap.size()), 32'(n));
    for (int i = 0; i < n && i < cap.size(); i++) check(32'(cap[i]), 32'(e[i]));
  endtask : chk_pkt
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    logic [7:0]  ofs[6];
    logic [31:0] rv[6];
    ofs = '{OFS_CTRL, OFS_LINE, OFS_SAMPLE, OFS_LINE_LIM, OFS_SAMPLE_LIM, 8'h30};
    rv = '{32'h0000_0004, 32'h0000_0009, 32'h0000_0000, 32'h0000_0029, 32'h0000_0780, 32'h0000_0000};
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    foreach (ofs[i]) begin
      rd_reg(ofs[i], v);
      check(v, rv[i]);
    end
    rd_reg(OFS_STATUS, v);
    check(v, 32'h0000_0001);
    wr_reg(OFS_AFD, 32'h0000_0019);
    wr_reg(OFS_FLAGS, 32'h0000_000A);
    wr_reg(OFS_BAR1, {16'h0000, bar1});
    wr_reg(OFS_BAR2, {16'h0000, bar2});
    wr_reg(OFS_CTRL, 32'h0000_0005);
    // back to back payload writes chain two rebuilds
    repeat (40) @(posedge clk_sys_i);
    run_line(11'h009, 12'h008);
    chk_pkt(1'b1, 15);
    run_line(11'h00A, 12'h03F);
    check(32'(cap.size()), 32'h0000_0000);
    run_line(11'h009, 12'h03F);
    chk_pkt(1'b1, 15);
    rd_reg(OFS_STATUS, v);
    check(v, 32'h0002_0001);
    wr_reg(OFS_LINE_LIM, 32'h0000_0008);
    run_line(11'h009, 12'h03F);
    check(32'(cap.size()), 32'h0000_0000);
    wr_reg(OFS_LINE_LIM, 32'h0000_0029);
    wr_reg(OFS_SAMPLE, 32'h0000_001E);
    run_line(11'h009, 12'h03F);
    chk_pkt(1'b1, 6);
    wr_reg(OFS_SAMPLE, 32'h0000_0000);
    wr_reg(OFS_CTRL, 32'h0000_0002);
    repeat (20) @(posedge clk_sys_i);
    run_line(11'h009, 12'h03F);
    chk_pkt(1'b0, 15);
    rd_reg(OFS_CTRL, v);
    check(v, 32'h0000_0000);
    rd_reg(OFS_STATUS, v);
    check(32'(v[2:0]), 32'h0000_0005);
    wr_reg(OFS_STATUS, 32'h0000_0004);
    rd_reg(OFS_STATUS, v);
    check(32'(v[2:0]), 32'h0000_0001);
    run_line(11'h009, 12'h03F);
    check(32'(cap.size()), 32'h0000_0000);
    csel = 1'b1;
    flg_b = '0;
    bar1 = '0;
    bar2 = '0;
    wr_reg(OFS_FLAGS, 32'h0000_0000);
    wr_reg(OFS_BAR1, 32'h0000_0000);
    wr_reg(OFS_BAR2, 32'h0000_0000);
    wr_reg(OFS_CTRL, 32'h0000_000E);
    repeat (40) @(posedge clk_sys_i);
    run_line(11'h009, 12'h03F);
    chk_pkt(1'b1, 15);
    test_done();
  end
  // watchdog well past the roughly 550 cycles the tests take
  initial begin
    repeat (4000) @(posedge clk_sys_i);
    error_cnt++;
    test_done();
  end
endmodule : afd_anc_packet_inserter_bench
`default_nettype wire
